// file: core/ocm_ctrl.v
`timescale 1ns/100ps
`include "ocm_consts.vh"

// What this block does
// - each fill data write puts exactly one 32-bit word into instruction RAM
// - lowest fill address bit picks the half for the next word
// - each fill data write toggles even and odd half enables
// - fill address holds 22 bits, loaded from bus bits 2 to 23
// - fill address bits 1 to 21 drive the 21-bit RAM write address
// - RAM write address advances by one after every fill data write
// - fill data bus bits 0 to 31 pass unchanged to RAM write data
// - reading fill address returns its bits on read data bits 10 to 31
// - instruction RAM writes and reads share the instruction memory clock
// - all control registers of both sides are readable and writable
// - each side's 8-bit base meets CPU address bits 24 to 31, 16 MB
// - window base and control values can also come from fabric inputs
// - RAM address outputs are bits 2-23 data side, 3-23 instruction side
// - ratio code is 2n-1; 111 means 4:1; even codes unsupported
// - forwarding disabled: load data latched directly, two cycle latency
// - forwarding enabled: load data steered then latched, one cycle latency
// - a side's decoder answers only while its enable bit is set
// - multi-cycle mode waits for aligned memory edge before a transfer
module ocm_ctrl #(
    parameter DW = 32
)(
    // clock and reset
    input  wire                   clk_i,
    input  wire                   rst_i,
    // control register bus
    input  wire [`OCM_ADDR_W-1:0] dcr_addr_i,
    input  wire                   dcr_rd_i,
    input  wire                   dcr_wr_i,
    input  wire [DW-1:0]          dcr_wdata_i,
    output reg  [DW-1:0]          dcr_rdata_o,
    output reg                    dcr_ack_o,
    // fabric configuration values
    input  wire [7:0]             data_window_base_input_i,
    input  wire [7:0]             data_control_input_i,
    input  wire [7:0]             instr_window_base_input_i,
    input  wire [7:0]             instr_control_input_i,
    // cpu requests
    input  wire                   data_req_i,
    input  wire [31:0]            data_addr_i,
    input  wire                   fetch_req_i,
    input  wire [31:0]            fetch_addr_i,
    // load data path
    input  wire                   load_valid_i,
    input  wire [DW-1:0]          load_data_i,
    output reg                    load_valid_o,
    output reg  [DW-1:0]          load_data_o,
    // data side memory
    output reg                    data_mem_ce_o,
    output reg                    data_start_o,
    output reg  [21:0]            data_ram_address_o,
    // instruction side memory
    output reg                    instr_mem_ce_o,
    output reg                    instr_start_o,
    output reg  [20:0]            instr_ram_read_address_o,
    input  wire                   instr_ram_ready_i,
    output reg  [20:0]            instr_ram_write_address_o,
    output reg  [DW-1:0]          instr_ram_write_data_o,
    output reg                    even_half_write_enable_o,
    output reg                    odd_half_write_enable_o,
    // status
    output reg                    ratio_unsupported_o
);

localparam FW = 21 + 1 + DW;

// n-1 for a ratio code of 2n-1; even codes fall back to 1:1
function [1:0] ocm_ratio;
    input [2:0] code;
    begin
        ocm_ratio = code[0] ? code[2:1] : 2'h0;
    end
endfunction

reg  [7:0]    data_window_base;
reg  [7:0]    data_side_control;
reg  [7:0]    instr_window_base;
reg  [7:0]    instr_side_control;
reg  [21:0]   instr_fill_address;
reg  [DW-1:0] instr_fill_data;
reg  [31:0]   strap_s1;
reg  [31:0]   strap_s2;
reg  [1:0]    strap_cnt;
reg           strap_done;
reg  [1:0]    data_div;
reg  [1:0]    instr_div;
reg  [DW-1:0] load_q1;
reg           load_v1;
reg  [DW-1:0] next_rdata;
wire          req;
wire          fill_sel;
wire          fill_wr;
wire          take;
wire          buf_in_ready;
wire          buf_out_valid;
wire          buf_pop;
wire [FW-1:0] buf_out;
wire          data_start;
wire          instr_start;
wire [21:0]   data_addr;
wire [20:0]   instr_addr;
wire [1:0]    data_n;
wire [1:0]    instr_n;
wire          fwd_dis;

assign req      = (dcr_rd_i | dcr_wr_i) & ~dcr_ack_o;
assign fill_sel = (dcr_addr_i == `OCM_INSTR_FILL_DATA);
// a fill write waits while the buffer is full, so no word is lost
assign take     = req & ~(dcr_wr_i & fill_sel & ~buf_in_ready);
assign fill_wr  = take & dcr_wr_i & fill_sel;
assign data_n   = ocm_ratio(data_side_control[`OCM_CTL_RATIO_HI:`OCM_CTL_RATIO_LO]);
assign instr_n  = ocm_ratio(instr_side_control[`OCM_CTL_RATIO_HI:`OCM_CTL_RATIO_LO]);
assign fwd_dis  = data_side_control[`OCM_CTL_FWD_DIS];
// drain only on an instruction memory edge that the RAM accepts
assign buf_pop  = instr_mem_ce_o & instr_ram_ready_i;

// fabric values cross in through two flip-flops
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        strap_s1 <= 32'h00000000;
        strap_s2 <= 32'h00000000;
    end
    else
    begin
        strap_s1 <= {data_window_base_input_i, data_control_input_i,
                     instr_window_base_input_i, instr_control_input_i};
        strap_s2 <= strap_s1;
    end
end

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        strap_cnt  <= 2'h0;
        strap_done <= 1'b0;
    end
    else if (!strap_done)
    begin
        if (strap_cnt == `OCM_STRAP_DLY)
            strap_done <= 1'b1;
        else
            strap_cnt <= strap_cnt + 2'h1;
    end
end

// register file
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        data_window_base   <= `OCM_BASE_RST;
        data_side_control  <= `OCM_CTL_RST;
        instr_window_base  <= `OCM_BASE_RST;
        instr_side_control <= `OCM_CTL_RST;
        instr_fill_address <= `OCM_FILL_ADDR_RST;
        instr_fill_data    <= `OCM_FILL_DATA_RST;
    end
    else if (!strap_done && strap_cnt == `OCM_STRAP_DLY)
    begin
        data_window_base   <= strap_s2[31:24];
        data_side_control  <= strap_s2[23:16] & `OCM_DATA_CTL_MASK;
        instr_window_base  <= strap_s2[15:8];
        instr_side_control <= strap_s2[7:0] & `OCM_INSTR_CTL_MASK;
    end
    else if (take && dcr_wr_i)
    begin
        case (dcr_addr_i)
            `OCM_DATA_WINDOW_BASE:
                data_window_base <= dcr_wdata_i[7:0];
            `OCM_DATA_SIDE_CONTROL:
                data_side_control <= dcr_wdata_i[7:0] & `OCM_DATA_CTL_MASK;
            `OCM_INSTR_WINDOW_BASE:
                instr_window_base <= dcr_wdata_i[7:0];
            `OCM_INSTR_SIDE_CTRL:
                instr_side_control <= dcr_wdata_i[7:0] & `OCM_INSTR_CTL_MASK;
            `OCM_INSTR_FILL_ADDR:
                instr_fill_address <= dcr_wdata_i[`OCM_FILL_WR_HI:`OCM_FILL_WR_LO];
            `OCM_INSTR_FILL_DATA:
            begin
                instr_fill_data <= dcr_wdata_i;
                // word address steps by one and the half select flips
                instr_fill_address <= {instr_fill_address[21:1] + 21'h000001,
                                       ~instr_fill_address[0]};
            end
            default:
                instr_fill_data <= instr_fill_data;
        endcase
    end
end

// read data and acknowledge; unmapped offsets read zero
always @*
begin
    next_rdata = 32'h00000000;
    case (dcr_addr_i)
        `OCM_DATA_WINDOW_BASE:  next_rdata = {24'h000000, data_window_base};
        `OCM_DATA_SIDE_CONTROL: next_rdata = {24'h000000, data_side_control};
        `OCM_INSTR_WINDOW_BASE: next_rdata = {24'h000000, instr_window_base};
        `OCM_INSTR_SIDE_CTRL:   next_rdata = {24'h000000, instr_side_control};
        `OCM_INSTR_FILL_ADDR:   next_rdata = {instr_fill_address, `OCM_FILL_RD_PAD};
        `OCM_INSTR_FILL_DATA:   next_rdata = instr_fill_data;
        default:                next_rdata = 32'h00000000;
    endcase
end

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        dcr_ack_o   <= 1'b0;
        dcr_rdata_o <= 32'h00000000;
    end
    else
    begin
        dcr_ack_o <= take;
        if (take && dcr_rd_i)
            dcr_rdata_o <= next_rdata;
        else if (take)
            dcr_rdata_o <= 32'h00000000;
    end
end

// memory clock enables: one pulse every n processor clocks
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        data_div            <= 2'h0;
        instr_div           <= 2'h0;
        data_mem_ce_o       <= 1'b0;
        instr_mem_ce_o      <= 1'b0;
        ratio_unsupported_o <= 1'b0;
    end
    else
    begin
        data_mem_ce_o  <= (data_div == 2'h0);
        instr_mem_ce_o <= (instr_div == 2'h0);
        data_div       <= (data_div == 2'h0) ? data_n : data_div - 2'h1;
        instr_div      <= (instr_div == 2'h0) ? instr_n : instr_div - 2'h1;
        ratio_unsupported_o <= ~data_side_control[`OCM_CTL_RATIO_LO] |
                               ~instr_side_control[`OCM_CTL_RATIO_LO];
    end
end

// fill words wait here for the next instruction memory edge
ocm_buf2 #(
    .WIDTH (FW)
) u_fill_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (fill_wr),
    .in_ready_o  (buf_in_ready),
    .in_data_i   ({instr_fill_address, dcr_wdata_i}),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_pop),
    .out_data_o  (buf_out)
);

// write port: enables last one memory cycle, from one edge to the next
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        instr_ram_write_address_o <= 21'h000000;
        instr_ram_write_data_o    <= 32'h00000000;
        even_half_write_enable_o  <= 1'b0;
        odd_half_write_enable_o   <= 1'b0;
    end
    else if (buf_pop && buf_out_valid)
    begin
        instr_ram_write_address_o <= buf_out[FW-1:DW+1];
        instr_ram_write_data_o    <= buf_out[DW-1:0];
        even_half_write_enable_o  <= ~buf_out[DW];
        odd_half_write_enable_o   <= buf_out[DW];
    end
    else if (instr_mem_ce_o)
    begin
        even_half_write_enable_o <= 1'b0;
        odd_half_write_enable_o  <= 1'b0;
    end
end

// address decoders for both windows
ocm_win #(
    .AW  (22),
    .LSB (2)
) u_data_win (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .base_i   (data_window_base),
    .en_i     (data_side_control[`OCM_CTL_DEC_EN]),
    .mem_ce_i (data_mem_ce_o),
    .req_i    (data_req_i),
    .addr_i   (data_addr_i),
    .start_o  (data_start),
    .addr_o   (data_addr),
    .wait_o   ()
);

ocm_win #(
    .AW  (21),
    .LSB (3)
) u_instr_win (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .base_i   (instr_window_base),
    .en_i     (instr_side_control[`OCM_CTL_DEC_EN]),
    .mem_ce_i (instr_mem_ce_o),
    .req_i    (fetch_req_i),
    .addr_i   (fetch_addr_i),
    .start_o  (instr_start),
    .addr_o   (instr_addr),
    .wait_o   ()
);

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        data_start_o             <= 1'b0;
        data_ram_address_o       <= 22'h000000;
        instr_start_o            <= 1'b0;
        instr_ram_read_address_o <= 21'h000000;
    end
    else
    begin
        data_start_o             <= data_start;
        data_ram_address_o       <= data_addr;
        instr_start_o            <= instr_start;
        instr_ram_read_address_o <= instr_addr;
    end
end

// load data: one stage when steered, two when forwarding is off
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        load_q1      <= 32'h00000000;
        load_v1      <= 1'b0;
        load_data_o  <= 32'h00000000;
        load_valid_o <= 1'b0;
    end
    else
    begin
        load_q1 <= load_data_i;
        load_v1 <= load_valid_i;
        if (fwd_dis)
        begin
            load_data_o  <= load_q1;
            load_valid_o <= load_v1;
        end
        else
        begin
            load_data_o  <= load_data_i;
            load_valid_o <= load_valid_i;
        end
    end
end

endmodule // ocm_ctrl

// file: core/ocm_consts.vh
`ifndef OCM_CONSTS_VH
`define OCM_CONSTS_VH

// control register bus word offsets
`define OCM_ADDR_W            10
`define OCM_DATA_WINDOW_BASE  10'h000
`define OCM_DATA_SIDE_CONTROL 10'h001
`define OCM_INSTR_WINDOW_BASE 10'h002
`define OCM_INSTR_SIDE_CTRL   10'h003
`define OCM_INSTR_FILL_ADDR   10'h004
`define OCM_INSTR_FILL_DATA   10'h005

// side control register fields (bit 7 is the leftmost bit of the byte)
`define OCM_CTL_DEC_EN        7
`define OCM_CTL_FWD_DIS       6
`define OCM_CTL_RATIO_HI      2
`define OCM_CTL_RATIO_LO      0
`define OCM_DATA_CTL_MASK     8'hC7
`define OCM_INSTR_CTL_MASK    8'h87

// reset values
`define OCM_BASE_RST          8'h00
`define OCM_CTL_RST           8'h00
`define OCM_FILL_ADDR_RST     22'h000000
`define OCM_FILL_DATA_RST     32'h00000000

// fill address placement on the bus (write lanes and read lanes differ)
`define OCM_FILL_WR_HI        23
`define OCM_FILL_WR_LO        2
`define OCM_FILL_RD_PAD       10'h000

// cycles after reset release before the fabric values are taken
`define OCM_STRAP_DLY         2'h3

// window compare uses the top address byte: a 16 MB window
`define OCM_WIN_HI            31
`define OCM_WIN_LO            24

`endif

// file: core/ocm_buf2.v
`timescale 1ns/100ps

module ocm_buf2 #(
    parameter WIDTH = 8
)(
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // filling side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // draining side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

reg [WIDTH-1:0] slot0;
reg [WIDTH-1:0] slot1;
reg [1:0]       count;
wire            push;
wire            pop;

assign in_ready_o  = (count != 2'h2);
assign out_valid_o = (count != 2'h0);
assign out_data_o  = slot0;
assign push        = in_valid_i & in_ready_o;
assign pop         = out_valid_o & out_ready_i;

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        slot0 <= {WIDTH{1'b0}};
        slot1 <= {WIDTH{1'b0}};
        count <= 2'h0;
    end
    else if (push && pop)
    begin
        if (count == 2'h1)
            slot0 <= in_data_i;
        else
        begin
            slot0 <= slot1;
            slot1 <= in_data_i;
        end
    end
    else if (pop)
    begin
        slot0 <= slot1;
        count <= count - 2'h1;
    end
    else if (push)
    begin
        if (count == 2'h0)
            slot0 <= in_data_i;
        else
            slot1 <= in_data_i;
        count <= count + 2'h1;
    end
end

endmodule // ocm_buf2

// file: core/ocm_win.v
`timescale 1ns/100ps
`include "ocm_consts.vh"

module ocm_win #(
    parameter AW  = 22,
    parameter LSB = 2
)(
    // clock and reset
    input  wire          clk_i,
    input  wire          rst_i,
    // configuration
    input  wire [7:0]    base_i,
    input  wire          en_i,
    input  wire          mem_ce_i,
    // cpu request
    input  wire          req_i,
    input  wire [31:0]   addr_i,
    // memory side
    output reg           start_o,
    output reg  [AW-1:0] addr_o,
    output wire          wait_o
);

reg        pend;
reg [31:0] addr_q;
wire       hit;

// top address byte against the window base, only while decoding is on
assign hit    = req_i & en_i & (addr_i[`OCM_WIN_HI:`OCM_WIN_LO] == base_i);
assign wait_o = pend;

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        pend    <= 1'b0;
        addr_q  <= 32'h00000000;
        start_o <= 1'b0;
        addr_o  <= {AW{1'b0}};
    end
    else
    begin
        start_o <= pend & mem_ce_i;
        if (hit)
        begin
            pend   <= 1'b1;
            addr_q <= addr_i;
        end
        else if (pend && mem_ce_i)
            pend <= 1'b0;
        if (pend && mem_ce_i)
            addr_o <= addr_q[LSB+AW-1:LSB];
    end
end

endmodule // ocm_win

// file: verif/ocm_ctrl_chk.sv
`timescale 1ns/100ps
`include "ocm_consts.vh"

module ocm_ctrl_chk (
    // clock and reset
    input wire                   clk_i,
    input wire                   rst_i,
    // register bus
    input wire [`OCM_ADDR_W-1:0] dcr_addr_i,
    input wire                   dcr_rd_i,
    input wire                   dcr_wr_i,
    input wire [31:0]            dcr_rdata_o,
    input wire                   dcr_ack_o,
    // load path and windows
    input wire                   load_valid_i,
    input wire                   load_valid_o,
    input wire                   data_mem_ce_o,
    input wire                   data_start_o,
    // fill port
    input wire                   instr_mem_ce_o,
    input wire [20:0]            instr_ram_write_address_o,
    input wire                   even_half_write_enable_o,
    input wire                   odd_half_write_enable_o
);
    wire        we  = even_half_write_enable_o | odd_half_write_enable_o;
    wire        put = we & instr_mem_ce_o;
    wire        rdk = dcr_ack_o & dcr_rd_i;
    reg         have;
    reg         last_odd;
    reg  [20:0] last_addr;

    // remembers the previous ram write; a new fill start breaks the chain
    always @(posedge clk_i or posedge rst_i)
        if (rst_i)
            have <= 1'h0;
        else if (dcr_wr_i && dcr_addr_i == `OCM_INSTR_FILL_ADDR)
            have <= 1'h0;
        else if (put)
            have <= 1'h1;

    always @(posedge clk_i)
        if (put)
        begin
            last_odd  <= odd_half_write_enable_o;
            last_addr <= instr_ram_write_address_o;
        end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_pulse: assert property (dcr_ack_o |=> !dcr_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (dcr_ack_o |-> $past(dcr_rd_i | dcr_wr_i))
        else $error("ack without request");
    a_ack_bound: assert property ((dcr_rd_i | dcr_wr_i) && !dcr_ack_o |-> ##[1:300] dcr_ack_o)
        else $error("request never acknowledged");
    a_half_excl: assert property (!(even_half_write_enable_o && odd_half_write_enable_o))
        else $error("both halves enabled");
    a_even_once: assert property (even_half_write_enable_o && instr_mem_ce_o |=> !even_half_write_enable_o)
        else $error("even enable spans two memory edges");
    a_odd_once: assert property (odd_half_write_enable_o && instr_mem_ce_o |=> !odd_half_write_enable_o)
        else $error("odd enable spans two memory edges");
    a_addr_step: assert property (put && have |-> instr_ram_write_address_o == last_addr + 21'h1)
        else $error("write address did not advance by one");
    a_half_toggle: assert property (put && have |-> odd_half_write_enable_o != last_odd)
        else $error("half did not alternate");
    a_fill_pad: assert property (rdk && dcr_addr_i == `OCM_INSTR_FILL_ADDR |-> dcr_rdata_o[9:0] == 10'h0)
        else $error("fill address read not left aligned");
    a_byte_upper: assert property (rdk && dcr_addr_i < `OCM_INSTR_FILL_ADDR |-> dcr_rdata_o[31:8] == 24'h0)
        else $error("byte register upper bits set");
    a_ctl_reserved: assert property (rdk && dcr_addr_i == `OCM_DATA_SIDE_CONTROL |-> (dcr_rdata_o[7:0] & ~`OCM_DATA_CTL_MASK) == 8'h0)
        else $error("reserved control bit reads set");
    a_start_on_ce: assert property (data_start_o |-> $past(data_mem_ce_o, 2))
        else $error("start off the memory edge");
    a_load_delay: assert property (load_valid_o |-> $past(load_valid_i) || $past(load_valid_i, 2))
        else $error("load output without load input");

    c_ram_write: cover property (put && have);
    c_fill_read: cover property (rdk && dcr_addr_i == `OCM_INSTR_FILL_ADDR);
    c_data_start: cover property (data_start_o);
    c_load_out: cover property (load_valid_o);
endmodule // ocm_ctrl_chk

bind ocm_ctrl ocm_ctrl_chk u_chk (.clk_i, .rst_i, .dcr_addr_i, .dcr_rd_i, .dcr_wr_i,
    .dcr_rdata_o, .dcr_ack_o, .load_valid_i, .load_valid_o, .data_mem_ce_o, .data_start_o,
    .instr_mem_ce_o, .instr_ram_write_address_o, .even_half_write_enable_o,
    .odd_half_write_enable_o);

// file: verif/ocm_ram_model.sv
`timescale 1ns/100ps

module ocm_ram_model (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // write port
    input  wire        mem_ce_i,
    input  wire        even_i,
    input  wire        odd_i,
    input  wire [20:0] addr_i,
    input  wire [31:0] data_i,
    output wire        ready_o,
    // test control
    input  wire        stall_i
);
    logic [53:0] log_q [$];

    // a stalled ram drops ready, so the buffer hands over no new word on the memory edge
    assign ready_o = ~stall_i;

    // writes land on the shared memory clock, only at a memory edge
    always @(posedge clk_i)
        if (!rst_i && mem_ce_i && (even_i || odd_i))
            log_q.push_back({odd_i, addr_i, data_i});
endmodule // ocm_ram_model

// file: verif/ocm_dcr_control_and_ifill_tb_top.sv
`timescale 1ns/100ps
`include "ocm_consts.vh"

module ocm_dcr_control_and_ifill_tb_top;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic [9:0]  dcr_addr_i = 10'h000;
    logic        dcr_rd_i = 1'h0;
    logic        dcr_wr_i = 1'h0;
    logic [31:0] dcr_wdata_i = 32'h0;
    logic        data_req_i = 1'h0, fetch_req_i = 1'h0, load_valid_i = 1'h0, stall = 1'h0;
    logic [31:0] data_addr_i = 32'h0, fetch_addr_i = 32'h0, load_data_i = 32'h0;
    wire  [31:0] dcr_rdata_o, load_data_o, instr_ram_write_data_o;
    wire         dcr_ack_o, load_valid_o, data_mem_ce_o, data_start_o, instr_mem_ce_o;
    wire         instr_start_o, instr_ram_ready_i, ratio_unsupported_o;
    wire         even_half_write_enable_o, odd_half_write_enable_o;
    wire  [21:0] data_ram_address_o;
    wire  [20:0] instr_ram_read_address_o, instr_ram_write_address_o;
    int          miscompares = 0, total_checks = 0, cycles = 0, la, lb, i;
    logic [31:0] rd;
    logic [73:0] rows [0:6];
    logic [31:0] init_v [0:5] = '{32'h3C, 32'h41, 32'h66, 32'h81, 32'h0, 32'h0};

    ocm_ctrl dut (.clk_i, .rst_i, .dcr_addr_i, .dcr_rd_i, .dcr_wr_i, .dcr_wdata_i, .dcr_rdata_o,
        .dcr_ack_o, .data_window_base_input_i(8'h3C), .data_control_input_i(8'h41),
        .instr_window_base_input_i(8'h66), .instr_control_input_i(8'h81), .data_req_i,
        .data_addr_i, .fetch_req_i, .fetch_addr_i, .load_valid_i, .load_data_i, .load_valid_o,
        .load_data_o, .data_mem_ce_o, .data_start_o, .data_ram_address_o, .instr_mem_ce_o,
        .instr_start_o, .instr_ram_read_address_o, .instr_ram_ready_i,
        .instr_ram_write_address_o, .instr_ram_write_data_o, .even_half_write_enable_o,
        .odd_half_write_enable_o, .ratio_unsupported_o);

    ocm_ram_model ram (.clk_i, .rst_i, .mem_ce_i(instr_mem_ce_o),
        .even_i(even_half_write_enable_o), .odd_i(odd_half_write_enable_o),
        .addr_i(instr_ram_write_address_o), .data_i(instr_ram_write_data_o),
        .ready_o(instr_ram_ready_i), .stall_i(stall));

    initial
        forever #50 clk_i = ~clk_i;

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test;
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask

    // request held until ack is sampled, dropped at that same edge
    task automatic dcr(input logic wr, input logic [9:0] a, input logic [31:0] w);
        int n;
        @(posedge clk_i);
        dcr_addr_i <= a;
        dcr_wdata_i <= w;
        dcr_rd_i <= ~wr;
        dcr_wr_i <= wr;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (dcr_ack_o !== 1'h1 && n < 400);
        rd = dcr_rdata_o;
        chk_flag(dcr_ack_o, 1'h1);
        dcr_rd_i <= 1'h0;
        dcr_wr_i <= 1'h0;
    endtask

    // ram stalls first, so the buffer fills and the bus stalls, then drains
    task automatic fill_run(input logic [21:0] s, input logic [7:0] ctl, input int n, input int hold);
        logic [53:0] e;
        dcr(1'h1, `OCM_INSTR_SIDE_CTRL, {24'h0, ctl});
        dcr(1'h1, `OCM_INSTR_FILL_ADDR, {8'h0, s, 2'h0});
        ram.log_q.delete();
        stall <= 1'h1;
        fork
            begin
                repeat (hold) @(posedge clk_i);
                stall <= 1'h0;
            end
        join_none
        for (int k = 0; k < n; k++)
            dcr(1'h1, `OCM_INSTR_FILL_DATA, 32'hC0DE0000 + k);
        repeat (40) @(posedge clk_i);
        chk_val(ram.log_q.size(), n);
        for (int k = 0; k < n; k++)
        begin
            e = ram.log_q[k];
            chk_val(e[52:32], 21'(s[21:1] + k));
            chk_flag(e[53], s[0] ^ k[0]);
            chk_val(e[31:0], 32'hC0DE0000 + k);
        end
        dcr(1'h0, `OCM_INSTR_FILL_ADDR, 32'h0);
        chk_val(rd, {21'(s[21:1] + n), s[0] ^ n[0], 10'h0});
    endtask

    task automatic win(input logic side, input logic [31:0] a, input logic hit, input logic [21:0] exp);
        logic seen;
        @(posedge clk_i);
        fetch_req_i <= side;
        data_req_i <= ~side;
        fetch_addr_i <= a;
        data_addr_i <= a;
        @(posedge clk_i);
        fetch_req_i <= 1'h0;
        data_req_i <= 1'h0;
        seen = 1'h0;
        repeat (20)
        begin
            @(negedge clk_i);
            if (!seen && (side ? instr_start_o : data_start_o) === 1'h1)
            begin
                seen = 1'h1;
                chk_val(side ? {1'h0, instr_ram_read_address_o} : data_ram_address_o, exp);
            end
        end
        chk_flag(seen, hit);
    endtask

    task automatic load_lat(output int lat);
        @(posedge clk_i);
        load_valid_i <= 1'h1;
        load_data_i <= 32'hA5A50F0F;
        @(posedge clk_i);
        load_valid_i <= 1'h0;
        lat = 0;
        for (int k = 1; k <= 4; k++)
        begin
            @(negedge clk_i);
            if (lat == 0 && load_valid_o === 1'h1)
            begin
                lat = k;
                chk_val(load_data_o, 32'hA5A50F0F);
            end
        end
    endtask

    initial
    begin
        rows[0] = {`OCM_DATA_WINDOW_BASE, 32'h000000A5, 32'h000000A5};
        rows[1] = {`OCM_DATA_SIDE_CONTROL, 32'h000000FF, 32'h000000C7};
        rows[2] = {`OCM_INSTR_WINDOW_BASE, 32'h0000005A, 32'h0000005A};
        rows[3] = {`OCM_INSTR_SIDE_CTRL, 32'h000000FF, 32'h00000087};
        rows[4] = {`OCM_INSTR_FILL_ADDR, 32'h00FFFFFC, 32'hFFFFFC00};
        rows[5] = {`OCM_INSTR_FILL_DATA, 32'h12345678, 32'h12345678};
        rows[6] = {10'h3FF, 32'hFFFFFFFF, 32'h00000000};
        repeat (10) @(posedge clk_i);
        chk_flag(even_half_write_enable_o | odd_half_write_enable_o | dcr_ack_o, 1'h0);
        rst_i <= 1'h0;
        repeat (6) @(posedge clk_i);
        for (i = 0; i < 6; i++)
        begin
            dcr(1'h0, i[9:0], 32'h0);
            chk_val(rd, init_v[i]);
        end
        chk_flag(ratio_unsupported_o, 1'h0);
        for (i = 0; i < 7; i++)
        begin
            dcr(1'h1, rows[i][73:64], rows[i][63:32]);
            dcr(1'h0, rows[i][73:64], 32'h0);
            chk_val(rd, rows[i][31:0]);
        end
        dcr(1'h1, `OCM_INSTR_SIDE_CTRL, 32'h82);
        repeat (3) @(negedge clk_i);
        chk_flag(ratio_unsupported_o, 1'h1);
        repeat (20) @(posedge clk_i);
        fill_run(22'h000247, 8'h81, 4, 20);
        fill_run(22'h000020, 8'h83, 3, 10);
        fill_run(22'h3FFFFC, 8'h87, 3, 30);
        dcr(1'h1, `OCM_DATA_WINDOW_BASE, 32'h3C);
        dcr(1'h1, `OCM_DATA_SIDE_CONTROL, 32'h41);
        win(1'h0, 32'h3C001234, 1'h0, 22'h0);
        dcr(1'h1, `OCM_DATA_SIDE_CONTROL, 32'h81);
        win(1'h0, 32'h3C001234, 1'h1, 22'h00048D);
        win(1'h0, 32'h3D001234, 1'h0, 22'h0);
        dcr(1'h1, `OCM_INSTR_WINDOW_BASE, 32'h66);
        dcr(1'h1, `OCM_INSTR_SIDE_CTRL, 32'h81);
        win(1'h1, 32'h66000010, 1'h1, 22'h000002);
        load_lat(la);
        chk_val(la, 32'h1);
        dcr(1'h1, `OCM_DATA_SIDE_CONTROL, 32'hC1);
        load_lat(lb);
        chk_val(lb - la, 32'h1);
        finish_test;
    end
endmodule // ocm_dcr_control_and_ifill_tb_top
